// ### include/pam_if.sv
// management access link between the station controller and the phy register slice
// assumes both ends run on one clock; no tri-state, data is point to point
`timescale 1ns/100ps
`default_nettype none
interface pam_if;
  logic mgmt_req;
  logic mgmt_we;
  pam_pkg::pam_addr_t mgmt_addr;
  pam_pkg::pam_word_t mgmt_wdata;
  pam_pkg::pam_word_t mgmt_rdata;
  logic mgmt_ack;
  logic phy_irq;
  modport phy (input mgmt_req, input mgmt_we, input mgmt_addr, input mgmt_wdata,
               output mgmt_rdata, output mgmt_ack, output phy_irq);
  modport sta (output mgmt_req, output mgmt_we, output mgmt_addr, output mgmt_wdata,
               input mgmt_rdata, input mgmt_ack, input phy_irq);
endinterface : pam_if
`default_nettype wire

// ### include/pam_map.svh
// register offsets, field positions, reset values and counts of the autoneg management slice
// assumes inclusion by bare name from both ends, the checker and the bench
`ifndef PAM_MAP_SVH
`define PAM_MAP_SVH
// device register offsets on the management port
`define PAM_ADDR_PARTNER 5'h05
`define PAM_ADDR_EXPANSION 5'h06
`define PAM_ADDR_LOCAL_NP 5'h07
`define PAM_ADDR_PARTNER_NP 5'h08
`define PAM_ADDR_PREAMBLE 5'h14
`define PAM_ADDR_SYMERR 5'h15
`define PAM_ADDR_INT 5'h1B
// field positions
`define PAM_NP_MORE 15
`define PAM_NP_ACK 14
`define PAM_NP_MSG_PAGE 13
`define PAM_NP_ACK2 12
`define PAM_NP_TOGGLE 11
`define PAM_PRE_RESTORE_100 7
`define PAM_PRE_RESTORE_10 6
`define PAM_INT_EN_LSB 12
`define PAM_INT_ST_LSB 4
// reset values
`define PAM_SELECTOR_RST 5'h01
`define PAM_MSG_FIELD_RST 11'h001
`define PAM_PRE_LOW_RST 6'h01
`define PAM_STRAP_RESTORE 3'h4
// preamble bytes removed per mode
`define PAM_DROP_100 3'h1
`define PAM_DROP_10 3'h7
// strap sampler settle count
`define PAM_STRAP_SETTLE 2'h3
// controller register offsets on the software port
`define PAM_HOST_CMD 2'h0
`define PAM_HOST_WDATA 2'h1
`define PAM_HOST_RDATA 2'h2
`define PAM_HOST_STATUS 2'h3
`define PAM_HOST_CMD_WR 8
`endif

// ### include/pam_pkg.sv
// shared types of the autoneg management slice
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package pam_pkg;
  typedef logic [4:0] pam_addr_t;
  typedef logic [15:0] pam_word_t;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} pam_sta_state_t;
endpackage : pam_pkg
`default_nettype wire

// ### rtl/pam_mgmt_ctrl.sv
// station management controller end: software command registers driving the link
// assumes the phy end answers each request with an ack exactly one cycle later
`timescale 1ns/100ps
`default_nettype none
`include "pam_map.svh"
module pam_mgmt_ctrl (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // software port
  input wire logic [1:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_we_i,
  input wire logic sw_re_i,
  output logic [15:0] sw_rdata_o,
  // link to the phy
  pam_if.sta link
);
  import pam_pkg::*;

  pam_sta_state_t state_ff;
  pam_addr_t cmd_addr_ff;
  logic cmd_we_ff;
  pam_word_t wdata_ff;
  pam_word_t rdata_ff;
  logic [15:0] sw_rdata_ff;
  logic go;

  // a command written while busy is dropped, not queued
  assign go = sw_we_i && (sw_addr_i == `PAM_HOST_CMD) && (state_ff == ST_IDLE);

  // command sequencer
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE: if (go) state_ff <= ST_REQ;
        ST_REQ: state_ff <= ST_WAIT;
        ST_WAIT: if (link.mgmt_ack) state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // command and write data latches; software words pass through unchanged
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmd_addr_ff <= 5'h00;
      cmd_we_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end
    else
    begin
      if (go)
      begin
        cmd_addr_ff <= sw_wdata_i[4:0];
        cmd_we_ff <= sw_wdata_i[`PAM_HOST_CMD_WR];
      end
      if (sw_we_i && (sw_addr_i == `PAM_HOST_WDATA) && (state_ff == ST_IDLE))
        wdata_ff <= sw_wdata_i;
    end
  end

  // read result capture
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_ff <= 16'h0000;
    else if (state_ff == ST_WAIT && link.mgmt_ack && !cmd_we_ff)
      rdata_ff <= link.mgmt_rdata;
  end

  // software read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sw_rdata_ff <= 16'h0000;
    else if (sw_re_i)
    begin
      case (sw_addr_i)
        `PAM_HOST_CMD: sw_rdata_ff <= {7'h00, cmd_we_ff, 3'h0, cmd_addr_ff};
        `PAM_HOST_WDATA: sw_rdata_ff <= wdata_ff;
        `PAM_HOST_RDATA: sw_rdata_ff <= rdata_ff;
        `PAM_HOST_STATUS: sw_rdata_ff <= {14'h0000, link.phy_irq, state_ff != ST_IDLE};
        default: sw_rdata_ff <= 16'h0000;
      endcase
    end
    else
      sw_rdata_ff <= 16'h0000;
  end

  // link drive
  assign link.mgmt_req = (state_ff == ST_REQ);
  assign link.mgmt_we = cmd_we_ff;
  assign link.mgmt_addr = cmd_addr_ff;
  assign link.mgmt_wdata = wdata_ff;
  assign sw_rdata_o = sw_rdata_ff;
endmodule : pam_mgmt_ctrl
`default_nettype wire

// ### rtl/pam_phy_regs.sv
// phy end: partner ability, expansion, next page, preamble, error counter and interrupt registers
// assumes status events are one-cycle pulses on sys_clk_i and the strap pins are static after reset
`timescale 1ns/100ps
`default_nettype none
`include "pam_map.svh"
// Summary of operation
// - read-only partner speed and duplex ability bits
// - partner selector field, resets to 00001
// - parallel detect fault latched high flag
// - local next page able always one
// - page received latched high flag
// - partner next page and autoneg able bits
// - writable more-pages and message page bits
// - software writes comply bit, resets zero
// - local toggle flips per sent page
// - writable 11-bit message code, reset 001
// - partner next page control bits read-only
// - 100M restore keeps preamble, else drop one
// - 100M restore resets from strap value 100
// - 16-bit symbol error frame counter
// - four writable interrupt enable bits
// - sticky self-clearing interrupt status bits
module pam_phy_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // management link
  pam_if.phy link,
  // partner base page abilities from negotiation logic
  input wire logic [2:0] partner_abil_i,
  input wire logic [4:0] partner_sel_i,
  input wire logic partner_np_able_i,
  input wire logic partner_an_able_i,
  // negotiation events
  input wire logic pd_fault_i,
  input wire logic page_rx_i,
  input wire logic [15:0] partner_np_i,
  input wire logic np_sent_i,
  input wire logic jabber_i,
  input wire logic rx_err_i,
  input wire logic sym_err_frame_i,
  // strap pins
  input wire logic [2:0] strap_cfg_i,
  // local next page word to the negotiation logic
  output logic [15:0] local_np_o,
  // receive byte path toward the mac
  input wire logic speed_100_i,
  input wire logic rx_valid_i,
  input wire logic rx_start_i,
  input wire logic [7:0] rx_data_i,
  output logic mac_valid_o,
  output logic [7:0] mac_data_o
);
  import pam_pkg::*;

  // address match on the current request
  function automatic logic hit(input pam_addr_t a, input pam_addr_t target);
    hit = (a == target);
  endfunction : hit
  logic wr, rd, partner_np_able_ff, partner_an_able_ff, pd_fault_lh_ff, page_rx_lh_ff, np_more_ff, msg_page_ff;
  logic ack2_ff, toggle_ff, restore_100_ff, restore_10_ff, strap_done_ff, ack_ff, mac_valid_ff;
  logic [1:0] strap_cnt_ff;
  logic [2:0] partner_abil_ff, strap_s1_ff, strap_s2_ff, strap_s3_ff, drop_n, pre_idx, pre_idx_ff;
  logic [3:0] int_en_ff, int_st_ff, int_ev;
  logic [4:0] partner_sel_ff;
  logic [7:0] mac_data_ff;
  logic [10:0] msg_field_ff;
  pam_word_t partner_np_ff, sym_cnt_ff, nxt_rdata, rdata_ff;
  // request decode; a request is either a read or a write, never both
  assign wr = link.mgmt_req && link.mgmt_we;
  assign rd = link.mgmt_req && !link.mgmt_we;
  // partner base page and capability snapshots
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      partner_abil_ff <= 3'h0;
      partner_sel_ff <= `PAM_SELECTOR_RST;
      partner_np_able_ff <= 1'b0;
      partner_an_able_ff <= 1'b0;
    end
    else
    begin
      partner_abil_ff <= partner_abil_i;
      partner_sel_ff <= partner_sel_i;
      partner_np_able_ff <= partner_np_able_i;
      partner_an_able_ff <= partner_an_able_i;
    end
  end
  // latched-high flags; an event in the read cycle survives the read
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pd_fault_lh_ff <= 1'b0;
      page_rx_lh_ff <= 1'b0;
    end
    else
    begin
      pd_fault_lh_ff <= pd_fault_i | (pd_fault_lh_ff & ~(rd & hit(link.mgmt_addr, `PAM_ADDR_EXPANSION)));
      page_rx_lh_ff <= page_rx_i | (page_rx_lh_ff & ~(rd & hit(link.mgmt_addr, `PAM_ADDR_EXPANSION)));
    end
  end
  // local next page fields written by software
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      np_more_ff <= 1'b0;
      msg_page_ff <= 1'b1;
      ack2_ff <= 1'b0;
      msg_field_ff <= `PAM_MSG_FIELD_RST;
    end
    else if (wr && hit(link.mgmt_addr, `PAM_ADDR_LOCAL_NP))
    begin
      np_more_ff <= link.mgmt_wdata[`PAM_NP_MORE];
      msg_page_ff <= link.mgmt_wdata[`PAM_NP_MSG_PAGE];
      ack2_ff <= link.mgmt_wdata[`PAM_NP_ACK2];
      msg_field_ff <= link.mgmt_wdata[10:0];
    end
  end
  // toggle flips after each transmitted page so the next word alternates
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      toggle_ff <= 1'b0;
    else if (np_sent_i)
      toggle_ff <= ~toggle_ff;
  end
  // received partner next page, taken whole when a page lands
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      partner_np_ff <= 16'h0000;
    else if (page_rx_i)
      partner_np_ff <= partner_np_i;
  end
  // strap sampler; config counts once stages two and three agree after settling
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap_s1_ff <= 3'h0;
      strap_s2_ff <= 3'h0;
      strap_s3_ff <= 3'h0;
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end
    else
    begin
      strap_s1_ff <= strap_cfg_i;
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (strap_cnt_ff != `PAM_STRAP_SETTLE)
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      else if (strap_s2_ff == strap_s3_ff)
        strap_done_ff <= 1'b1;
    end
  end
  // preamble restore controls
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      restore_100_ff <= 1'b0;
      restore_10_ff <= 1'b0;
    end
    else
    begin
      if (!strap_done_ff && strap_cnt_ff == `PAM_STRAP_SETTLE && strap_s2_ff == strap_s3_ff)
        restore_100_ff <= (strap_s3_ff == `PAM_STRAP_RESTORE);
      else if (wr && hit(link.mgmt_addr, `PAM_ADDR_PREAMBLE))
        restore_100_ff <= link.mgmt_wdata[`PAM_PRE_RESTORE_100];
      if (wr && hit(link.mgmt_addr, `PAM_ADDR_PREAMBLE))
        restore_10_ff <= link.mgmt_wdata[`PAM_PRE_RESTORE_10];
    end
  end
  // symbol error frame counter; a hit in the read cycle counts as one
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sym_cnt_ff <= 16'h0000;
    else if (rd && hit(link.mgmt_addr, `PAM_ADDR_SYMERR))
      sym_cnt_ff <= {15'h0000, sym_err_frame_i};
    else if (sym_err_frame_i && sym_cnt_ff != 16'hFFFF)
      sym_cnt_ff <= sym_cnt_ff + 16'h0001;
  end

  // interrupt enables and sticky status, ordered jabber, rx error, page, fault
  assign int_ev = {jabber_i, rx_err_i, page_rx_i, pd_fault_i};
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      int_en_ff <= 4'h0;
      int_st_ff <= 4'h0;
    end
    else
    begin
      if (wr && hit(link.mgmt_addr, `PAM_ADDR_INT))
        int_en_ff <= link.mgmt_wdata[`PAM_INT_EN_LSB +: 4];
      int_st_ff <= int_ev | (int_st_ff & ~{4{rd & hit(link.mgmt_addr, `PAM_ADDR_INT)}});
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = 16'h0000;
    case (link.mgmt_addr)
      `PAM_ADDR_PARTNER: nxt_rdata = {8'h00, partner_abil_ff, partner_sel_ff};
      `PAM_ADDR_EXPANSION: nxt_rdata = {11'h000, pd_fault_lh_ff, partner_np_able_ff, 1'b1, page_rx_lh_ff,
                                        partner_an_able_ff};
      `PAM_ADDR_LOCAL_NP: nxt_rdata = local_np_o;
      `PAM_ADDR_PARTNER_NP: nxt_rdata = partner_np_ff;
      `PAM_ADDR_PREAMBLE: nxt_rdata = {8'h00, restore_100_ff, restore_10_ff, `PAM_PRE_LOW_RST};
      `PAM_ADDR_SYMERR: nxt_rdata = sym_cnt_ff;
      `PAM_ADDR_INT: nxt_rdata = {int_en_ff, 4'h0, int_st_ff, 4'h0};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // answer one cycle after each request; read data only with the ack
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_ff <= 16'h0000;
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= link.mgmt_req;
      rdata_ff <= rd ? nxt_rdata : 16'h0000;
    end
  end

  // preamble filter: bytes ahead of index drop_n are withheld from the mac
  assign drop_n = speed_100_i ? (restore_100_ff ? 3'h0 : `PAM_DROP_100)
                              : (restore_10_ff ? 3'h0 : `PAM_DROP_10);
  assign pre_idx = rx_start_i ? 3'h0 : pre_idx_ff;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pre_idx_ff <= 3'h0;
      mac_valid_ff <= 1'b0;
      mac_data_ff <= 8'h00;
    end
    else
    begin
      mac_valid_ff <= rx_valid_i && (pre_idx >= drop_n);
      if (rx_valid_i)
      begin
        mac_data_ff <= rx_data_i;
        pre_idx_ff <= (pre_idx == 3'h7) ? 3'h7 : pre_idx + 3'h1; // saturate so long frames stay open
      end
    end
  end
  // outputs straight from flops; the interrupt line is only a gate of flops
  assign local_np_o = {np_more_ff, 1'b0, msg_page_ff, ack2_ff, toggle_ff, msg_field_ff};
  assign link.mgmt_rdata = rdata_ff;
  assign link.mgmt_ack = ack_ff;
  assign link.phy_irq = |(int_en_ff & int_st_ff);
  assign mac_valid_o = mac_valid_ff;
  assign mac_data_o = mac_data_ff;
endmodule : pam_phy_regs
`default_nettype wire

// ### verification/pam_chk.sv
// link checker: answer timing and fixed read fields of the phy end
// assumes one clock; instantiated by the bench beside the link interface
`timescale 1ns/100ps
`default_nettype none
`include "pam_map.svh"
module pam_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // link signals
  input wire logic mgmt_req,
  input wire logic mgmt_we,
  input wire pam_pkg::pam_addr_t mgmt_addr,
  input wire pam_pkg::pam_word_t mgmt_wdata,
  input wire pam_pkg::pam_word_t mgmt_rdata,
  input wire logic mgmt_ack,
  input wire logic phy_irq
);
  import pam_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // a read request of one phy register
  sequence rd_of(logic [4:0] a);
    mgmt_req && !mgmt_we && mgmt_addr == a;
  endsequence
  // handshake: exactly one cycle from request to answer
  ack_after_req_a: assert property (mgmt_req |=> mgmt_ack) else $error("ack missing after request");
  ack_has_cause_a: assert property (mgmt_ack |-> $past(mgmt_req)) else $error("ack without request");
  rdata_idle_a: assert property (!mgmt_ack |-> mgmt_rdata == 16'h0000) else $error("read data outside ack");
  write_rdata_a: assert property (mgmt_req && mgmt_we |=> mgmt_rdata == 16'h0000) else $error("write data echo");
  // fixed fields seen in read answers
  np_able_set_a: assert property (rd_of(`PAM_ADDR_EXPANSION) |=>
    mgmt_rdata[2] && mgmt_rdata[15:5] == 11'h000) else $error("expansion fixed bits wrong");
  partner_upper_a: assert property (rd_of(`PAM_ADDR_PARTNER) |=>
    mgmt_rdata[15:8] == 8'h00) else $error("partner upper bits not zero");
  preamble_fixed_a: assert property (rd_of(`PAM_ADDR_PREAMBLE) |=>
    mgmt_rdata[15:8] == 8'h00 && mgmt_rdata[5:0] == 6'h01) else $error("preamble fixed bits wrong");
  int_gaps_a: assert property (rd_of(`PAM_ADDR_INT) |=>
    mgmt_rdata[11:8] == 4'h0 && mgmt_rdata[3:0] == 4'h0) else $error("interrupt unused bits set");
  np_reserved_a: assert property (rd_of(`PAM_ADDR_LOCAL_NP) |=>
    !mgmt_rdata[14]) else $error("next page reserved bit set");
endmodule : pam_chk
`default_nettype wire

// ### verification/phy_autoneg_mgmt_registers_tb.sv
// self-checking bench: controller and phy register slice joined by the link
// assumes a 200 MHz clock and asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "pam_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("mismatch %0t: %h not %h", $time, g, e); end end
module phy_autoneg_mgmt_registers_tb;
  import pam_pkg::*;
  logic sys_clk_i = 0, arst_n_i = 0, sw_we = 0, sw_re = 0, spd = 0, rxv = 0, rxs = 0, t = 0, mval;
  logic [1:0] sw_addr = 0, able = 0;
  logic [2:0] abil = 0, strap = 3'h4;
  logic [4:0] sel = 5'h01;
  logic [5:0] ev = 0;
  logic [7:0] rxd = 0, mdat, first;
  pam_word_t sw_wdata = 0, sw_rdata, lnp, d, w, pnp = 0;
  int fail_count = 0, n_tests = 0, seed = 28905, mcnt = 0, n, k;
  pam_addr_t ra[8] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h14, 5'h15, 5'h1B, 5'h1F};
  pam_word_t rv[8] = '{16'h0001, 16'h0004, 16'h2001, 16'h0000, 16'h0081, 16'h0000, 16'h0000, 16'h0000};
  pam_if link();
  pam_mgmt_ctrl u_pam_mgmt_ctrl (.sys_clk_i, .arst_n_i, .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_we_i(sw_we), .sw_re_i(sw_re), .sw_rdata_o(sw_rdata), .link(link.sta));
  pam_phy_regs u_pam_phy_regs (.sys_clk_i, .arst_n_i, .link(link.phy), .partner_abil_i(abil),
    .partner_sel_i(sel), .partner_np_able_i(able[1]), .partner_an_able_i(able[0]), .pd_fault_i(ev[5]),
    .page_rx_i(ev[4]), .partner_np_i(pnp), .np_sent_i(ev[3]), .jabber_i(ev[2]), .rx_err_i(ev[1]),
    .sym_err_frame_i(ev[0]), .strap_cfg_i(strap), .local_np_o(lnp), .speed_100_i(spd), .rx_valid_i(rxv),
    .rx_start_i(rxs), .rx_data_i(rxd), .mac_valid_o(mval), .mac_data_o(mdat));
  pam_chk u_pam_chk (.sys_clk_i, .arst_n_i, .mgmt_req(link.mgmt_req), .mgmt_we(link.mgmt_we),
    .mgmt_addr(link.mgmt_addr), .mgmt_wdata(link.mgmt_wdata), .mgmt_rdata(link.mgmt_rdata),
    .mgmt_ack(link.mgmt_ack), .phy_irq(link.phy_irq));
  // free-running system clock
  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // count bytes handed to the mac, keep the first one
  always @(posedge sys_clk_i)
    if (mval === 1'b1)
    begin
      if (mcnt == 0)
        first = mdat;
      mcnt++;
    end
  function automatic int drop(input logic s, input logic r100, input logic r10);
    return s ? (r100 ? 0 : 1) : (r10 ? 0 : 7);
  endfunction : drop
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic sw_wr(input logic [1:0] a, input pam_word_t v);
    @(posedge sys_clk_i);
    sw_we <= 1'h1;
    sw_addr <= a;
    sw_wdata <= v;
    @(posedge sys_clk_i);
    sw_we <= 1'h0;
  endtask : sw_wr
  task automatic sw_rd(input logic [1:0] a, output pam_word_t v);
    @(posedge sys_clk_i);
    sw_re <= 1'h1;
    sw_addr <= a;
    @(posedge sys_clk_i);
    sw_re <= 1'h0;
    #1;
    v = sw_rdata;
  endtask : sw_rd
  // one phy access through the controller; busy is polled under a bound
  task automatic phy(input logic we, input pam_addr_t a, input pam_word_t v, output pam_word_t r);
    int c;
    if (we)
      sw_wr(`PAM_HOST_WDATA, v);
    sw_wr(`PAM_HOST_CMD, {7'h00, we, 3'h0, a});
    c = 0;
    do
    begin
      sw_rd(`PAM_HOST_STATUS, r);
      c++;
    end
    while (r[0] !== 1'b0 && c < 20);
    if (c >= 20)
      fail_count++;
    sw_rd(`PAM_HOST_RDATA, r);
  endtask : phy
  task automatic pulse(input logic [5:0] m);
    @(posedge sys_clk_i);
    ev <= m;
    @(posedge sys_clk_i);
    ev <= 6'h00;
  endtask : pulse
  // preamble bytes carry their own index as data
  task automatic frame(input int nb);
    for (int i = 0; i < nb; i++)
    begin
      @(posedge sys_clk_i);
      rxv <= 1'h1;
      rxs <= (i == 0);
      rxd <= i[7:0];
    end
    @(posedge sys_clk_i);
    rxv <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask : frame
  // hang guard, far beyond the several hundred cycles the tests need
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      phy(1'b0, ra[i], 16'h0000, d);
      `CHK(d, rv[i])
    end
    `CHK(lnp, 16'h2001)
    // random partner abilities; writes to the read-only page are ignored
    repeat (3)
    begin
      w = $random(seed);
      abil <= w[7:5];
      sel <= w[4:0];
      able <= w[9:8];
      phy(1'b1, `PAM_ADDR_PARTNER, 16'hFFFF, d);
      phy(1'b0, `PAM_ADDR_PARTNER, 16'h0000, d);
      `CHK(d, {8'h00, w[7:0]})
      phy(1'b0, `PAM_ADDR_EXPANSION, 16'h0000, d);
      `CHK(d, {11'h000, 1'b0, w[9], 1'b1, 1'b0, w[8]})
    end
    // latched flags and received next page
    pnp <= $random(seed);
    pulse(6'h30);
    phy(1'b0, `PAM_ADDR_EXPANSION, 16'h0000, d);
    `CHK(d, {11'h000, 1'b1, able[1], 1'b1, 1'b1, able[0]})
    phy(1'b0, `PAM_ADDR_PARTNER_NP, 16'h0000, d);
    `CHK(d, pnp)
    phy(1'b0, `PAM_ADDR_EXPANSION, 16'h0000, d);
    `CHK(d, {11'h000, 1'b0, able[1], 1'b1, 1'b0, able[0]})
    // masked event leaves the line low, enabled one raises it
    phy(1'b1, `PAM_ADDR_INT, 16'h8000, d);
    pulse(6'h02);
    sw_rd(`PAM_HOST_STATUS, d);
    `CHK(d[1], 1'b0)
    pulse(6'h04);
    sw_rd(`PAM_HOST_STATUS, d);
    `CHK(d[1], 1'b1)
    phy(1'b0, `PAM_ADDR_INT, 16'h0000, d);
    `CHK(d, 16'h80F0)
    phy(1'b0, `PAM_ADDR_INT, 16'h0000, d);
    `CHK(d, 16'h8000)
    `CHK(link.phy_irq, 1'b0)
    // outgoing next page, toggle flips per page sent
    repeat (2)
    begin
      w = $random(seed);
      phy(1'b1, `PAM_ADDR_LOCAL_NP, w, d);
      phy(1'b0, `PAM_ADDR_LOCAL_NP, 16'h0000, d);
      `CHK(d, {w[15], 1'b0, w[13:12], t, w[10:0]})
      `CHK(lnp, {w[15], 1'b0, w[13:12], t, w[10:0]})
      pulse(6'h08);
      t = ~t;
      phy(1'b0, `PAM_ADDR_LOCAL_NP, 16'h0000, d);
      `CHK(d[11], t)
    end
    // error frame count, cleared by its read
    n = ({$random(seed)} % 5) + 1;
    repeat (n) pulse(6'h01);
    phy(1'b0, `PAM_ADDR_SYMERR, 16'h0000, d);
    `CHK(d, n[15:0])
    phy(1'b0, `PAM_ADDR_SYMERR, 16'h0000, d);
    `CHK(d, 16'h0000)
    // every speed and restore combination
    for (int m = 0; m < 8; m++)
    begin
      spd <= m[2];
      phy(1'b1, `PAM_ADDR_PREAMBLE, {8'h00, m[1:0], 6'h00}, d);
      phy(1'b0, `PAM_ADDR_PREAMBLE, 16'h0000, d);
      `CHK(d, {8'h00, m[1:0], 6'h01})
      k = drop(m[2], m[1], m[0]);
      mcnt = 0;
      frame(12);
      `CHK(mcnt, 12 - k)
      `CHK(first, k[7:0])
    end
    // reset again mid-run with another strap; the 100M restore must come up clear
    strap <= 3'h3;
    arst_n_i <= 1'h0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'h1;
    `CHK(lnp, 16'h2001)
    repeat (6) @(posedge sys_clk_i);
    phy(1'b0, `PAM_ADDR_PREAMBLE, 16'h0000, d);
    `CHK(d, 16'h0001)
    end_sim();
  end
endmodule : phy_autoneg_mgmt_registers_tb
`default_nettype wire
